// *** logic/gcfr_consts.svh ***
/*
 * offsets, field positions, reset values and write masks of the global
 * control and state-machine clock register bank.
 * assumes nothing; definitions only, included by bare name.
 */
`ifndef GCFR_CONSTS_SVH
`define GCFR_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets on the serial port
// ----------------------------------------------------------------------
`define GCFR_OFS_GLOBAL       7'h00
`define GCFR_OFS_FSM_CLK      7'h02
`define GCFR_OFS_CH_CTRL      7'h03
`define GCFR_OFS_OUT_EN_A     7'h04

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GCFR_RST_GLOBAL       16'h0000
`define GCFR_RST_FSM_CLK      16'h0223
`define GCFR_RST_CH_CTRL      16'hff86
`define GCFR_RST_OUT_EN_A     16'h36ff

// ----------------------------------------------------------------------
// writable bits; the rest are read-only reserved and read as zero
// ----------------------------------------------------------------------
`define GCFR_WMASK_GLOBAL     16'hffff
`define GCFR_WMASK_FSM_CLK    16'h07ff
`define GCFR_WMASK_CH_CTRL    16'hff87
`define GCFR_WMASK_OUT_EN_A   16'h3fff

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define GCFR_BIT_SOFT_RST     0
`define GCFR_BIT_LOW_POWER    2
`define GCFR_BIT_GEN_ON       5
`define GCFR_PRE_LSB          6
`define GCFR_PRE_MSB          9
`define GCFR_DIV_LSB          0
`define GCFR_DIV_MSB          2
`define GCFR_CAL_SIL_LSB      7
`define GCFR_LOGIC_CAL_SIL    11
`define GCFR_PAIR_ON_LSB      12
`define GCFR_OUT_CLK_LSB      0
`define GCFR_OUT_REF_LSB      4

// ----------------------------------------------------------------------
// serial frame: read flag, 7 address bits, 16 data bits
// ----------------------------------------------------------------------
`define GCFR_FRAME_HDR_BITS   5'h08
`define GCFR_FRAME_BITS       5'h18

`endif

// *** logic/gcfr_pkg.sv ***
/*
 * types shared by the register bank and its serial port.
 * assumes the consts header for all numeric values.
 */
`default_nettype none

package gcfr_pkg;
   typedef logic [6:0]  gcfr_addr_t;
   typedef logic [15:0] gcfr_data_t;
   typedef logic [4:0]  gcfr_bitcnt_t;
endpackage

`default_nettype wire

// *** logic/gcfr_serial_port.sv ***
/*
 * serial register port: 24-bit frames, read flag first, msb first,
 * sampled on rising sck, read data driven after falling sck.
 * assumes sck high and low each last at least three clk_sys periods.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gcfr_consts.svh"

module gcfr_serial_port (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              spi_sck,
   input  wire logic              spi_cs_b,
   input  wire logic              spi_sdi,
   output logic                   spi_sdo,
   output gcfr_pkg::gcfr_addr_t   addr,
   output gcfr_pkg::gcfr_data_t   wdata,
   output logic                   wr_stb,
   input  wire gcfr_pkg::gcfr_data_t rdata
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [2:0]               s1_r;
   logic [2:0]               s2_r;
   logic                     sck_d_r;
   gcfr_pkg::gcfr_bitcnt_t   cnt_r,   cnt_nxt;
   logic [22:0]              sh_r,    sh_nxt;
   logic                     rd_r,    rd_nxt;
   gcfr_pkg::gcfr_data_t     osh_r,   osh_nxt;
   logic                     sdo_nxt;
   gcfr_pkg::gcfr_addr_t     addr_nxt;
   gcfr_pkg::gcfr_data_t     wdata_nxt;
   logic                     wr_nxt;
   logic                     rise;
   logic                     fall;
   logic                     cs_b;
   logic                     sdi;

   assign cs_b = s2_r[1];
   assign sdi  = s2_r[0];
   assign rise = s2_r[2] & ~sck_d_r;
   assign fall = ~s2_r[2] & sck_d_r;

   // ----------------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------------
   // pins are asynchronous, so nothing reads them before two flops
   always_comb begin
      cnt_nxt   = cnt_r;
      sh_nxt    = sh_r;
      rd_nxt    = rd_r;
      osh_nxt   = osh_r;
      sdo_nxt   = spi_sdo;
      addr_nxt  = addr;
      wdata_nxt = wdata;
      wr_nxt    = 1'b0;
      if (cs_b) begin
         cnt_nxt = '0;          // a short frame is dropped without effect
      end else if (rise && cnt_r != `GCFR_FRAME_BITS) begin
         sh_nxt  = {sh_r[21:0], sdi};
         cnt_nxt = cnt_r + 5'h01;
         if (cnt_nxt == `GCFR_FRAME_HDR_BITS) begin
            rd_nxt   = sh_r[6];
            addr_nxt = {sh_r[5:0], sdi};
         end
         if (cnt_nxt == `GCFR_FRAME_BITS && !rd_r) begin
            wdata_nxt = {sh_r[14:0], sdi};
            wr_nxt    = 1'b1;
         end
      end else if (fall && rd_r && cnt_r >= `GCFR_FRAME_HDR_BITS) begin
         if (cnt_r == `GCFR_FRAME_HDR_BITS) begin
            sdo_nxt = rdata[15];
            osh_nxt = {rdata[14:0], 1'b0};
         end else begin
            sdo_nxt = osh_r[15];
            osh_nxt = {osh_r[14:0], 1'b0};
         end
      end
   end

   // registers only
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s1_r    <= 3'h7;
         s2_r    <= 3'h7;
         sck_d_r <= 1'b1;
         cnt_r   <= '0;
         sh_r    <= '0;
         rd_r    <= 1'b0;
         osh_r   <= '0;
         spi_sdo <= 1'b0;
         addr    <= '0;
         wdata   <= '0;
         wr_stb  <= 1'b0;
      end else begin
         s1_r    <= {spi_sck, spi_cs_b, spi_sdi};
         s2_r    <= s1_r;
         sck_d_r <= s2_r[2];
         cnt_r   <= cnt_nxt;
         sh_r    <= sh_nxt;
         rd_r    <= rd_nxt;
         osh_r   <= osh_nxt;
         spi_sdo <= sdo_nxt;
         addr    <= addr_nxt;
         wdata   <= wdata_nxt;
         wr_stb  <= wr_nxt;
      end
   end

endmodule

`default_nettype wire

// *** logic/gcfr_regbank.sv ***
/*
 * global control and state-machine clock register bank with its serial
 * port, state-machine clock divider and output enable gating.
 * assumes cal_active comes from logic on clk_sys and that clk_sys stands
 * for the input clock that feeds the state-machine clock divider.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gcfr_consts.svh"

module gcfr_regbank #(
   parameter int PAIRS = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             spi_sck,
   input  wire logic             spi_cs_b,
   input  wire logic             spi_sdi,
   output logic                  spi_sdo,
   input  wire logic             cal_active,
   output logic [PAIRS-1:0]      pair_clock_en,
   output logic [PAIRS-1:0]      pair_ref_en,
   output logic                  fabric_clock_en,
   output logic                  fabric_ref_en,
   output logic                  low_power_hold,
   output logic                  fsm_tick
);

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   // reserved codes fall back to the slowest pre-divide, the safe choice
   function automatic logic [3:0] gcfr_pre_factor(input logic [3:0] code);
      unique case (code)
         4'h2:    gcfr_pre_factor = 4'h2;
         4'h4:    gcfr_pre_factor = 4'h4;
         default: gcfr_pre_factor = 4'h8;
      endcase
   endfunction

   function automatic logic [10:0] gcfr_period(input logic [15:0] fsm, input logic [15:0] ch);
      gcfr_period = 11'({7'h00, gcfr_pre_factor(fsm[`GCFR_PRE_MSB:`GCFR_PRE_LSB])}
                        << ch[`GCFR_DIV_MSB:`GCFR_DIV_LSB]);
   endfunction

   // ----------------------------------------------------------------------
   // serial port
   // ----------------------------------------------------------------------
   gcfr_pkg::gcfr_addr_t   addr;
   gcfr_pkg::gcfr_data_t   wdata;
   gcfr_pkg::gcfr_data_t   rdata;
   logic                   wr_stb;

   gcfr_serial_port u_port (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .spi_sck  (spi_sck),
      .spi_cs_b (spi_cs_b),
      .spi_sdi  (spi_sdi),
      .spi_sdo  (spi_sdo),
      .addr     (addr),
      .wdata    (wdata),
      .wr_stb   (wr_stb),
      .rdata    (rdata)
   );

   // ----------------------------------------------------------------------
   // registers and divider
   // ----------------------------------------------------------------------
   gcfr_pkg::gcfr_data_t   glb_r,  glb_nxt;
   gcfr_pkg::gcfr_data_t   fsm_r,  fsm_nxt;
   gcfr_pkg::gcfr_data_t   ch_r,   ch_nxt;
   gcfr_pkg::gcfr_data_t   oe_r,   oe_nxt;
   logic [9:0]             cnt_r,  cnt_nxt;
   logic [10:0]            period;
   logic [PAIRS-1:0]       pclk_nxt;
   logic [PAIRS-1:0]       pref_nxt;
   logic                   fclk_nxt;
   logic                   lp_nxt;
   logic                   tick_nxt;
   logic                   srst_wr;
   logic                   lp;

   assign period  = gcfr_period(fsm_r, ch_r);
   assign srst_wr = wr_stb && addr == `GCFR_OFS_GLOBAL && wdata[`GCFR_BIT_SOFT_RST];
   assign lp      = glb_r[`GCFR_BIT_LOW_POWER];

   // read mux; the stored masks keep reserved read-only bits at zero
   always_comb begin
      unique case (addr)
         `GCFR_OFS_GLOBAL:   rdata = glb_r;
         `GCFR_OFS_FSM_CLK:  rdata = fsm_r;
         `GCFR_OFS_CH_CTRL:  rdata = ch_r;
         `GCFR_OFS_OUT_EN_A: rdata = oe_r;
         default:            rdata = '0;
      endcase
   end

   // register writes; a soft reset write reloads every default at once and leaves the soft reset bit set
   always_comb begin
      glb_nxt = glb_r;
      fsm_nxt = fsm_r;
      ch_nxt  = ch_r;
      oe_nxt  = oe_r;
      if (srst_wr) begin
         glb_nxt = `GCFR_RST_GLOBAL | 16'h0001;
         fsm_nxt = `GCFR_RST_FSM_CLK;
         ch_nxt  = `GCFR_RST_CH_CTRL;
         oe_nxt  = `GCFR_RST_OUT_EN_A;
      end else if (wr_stb) begin
         glb_nxt[`GCFR_BIT_SOFT_RST] = 1'b0;
         unique case (addr)
            `GCFR_OFS_GLOBAL:   glb_nxt = wdata & `GCFR_WMASK_GLOBAL;
            `GCFR_OFS_FSM_CLK:  fsm_nxt = wdata & `GCFR_WMASK_FSM_CLK;
            `GCFR_OFS_CH_CTRL:  ch_nxt  = wdata & `GCFR_WMASK_CH_CTRL;
            `GCFR_OFS_OUT_EN_A: oe_nxt  = wdata & `GCFR_WMASK_OUT_EN_A;
            default: ;                                               // unmapped writes vanish
         endcase
      end
   end

   // state-machine clock: one tick per pre-divide times 2^divide input clocks
   always_comb begin
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (glb_r[`GCFR_BIT_SOFT_RST] || lp || !fsm_r[`GCFR_BIT_GEN_ON]) begin
         cnt_nxt = '0;
      end else if ({1'b0, cnt_r} >= period - 11'h001) begin
         cnt_nxt  = '0;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 10'h001;
      end
   end

   // output gating; pair enable wins over every other enable
   always_comb begin
      for (int i = 0; i < PAIRS; i++) begin
         pclk_nxt[i] = ch_r[`GCFR_PAIR_ON_LSB+i] && !lp
                       && !(cal_active && ch_r[`GCFR_CAL_SIL_LSB+i])
                       && oe_r[`GCFR_OUT_CLK_LSB+i];
         pref_nxt[i] = ch_r[`GCFR_PAIR_ON_LSB+i] && !lp
                       && !(cal_active && ch_r[`GCFR_CAL_SIL_LSB+i])
                       && oe_r[`GCFR_OUT_REF_LSB+i];
      end
      fclk_nxt = !lp && !(cal_active && ch_r[`GCFR_LOGIC_CAL_SIL]);
      lp_nxt   = lp;
   end

   // registers only
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         glb_r           <= `GCFR_RST_GLOBAL;
         fsm_r           <= `GCFR_RST_FSM_CLK;
         ch_r            <= `GCFR_RST_CH_CTRL;
         oe_r            <= `GCFR_RST_OUT_EN_A;
         cnt_r           <= '0;
         pair_clock_en   <= '0;
         pair_ref_en     <= '0;
         fabric_clock_en <= 1'b0;
         fabric_ref_en   <= 1'b0;
         low_power_hold  <= 1'b0;
         fsm_tick        <= 1'b0;
      end else begin
         glb_r           <= glb_nxt;
         fsm_r           <= fsm_nxt;
         ch_r            <= ch_nxt;
         oe_r            <= oe_nxt;
         cnt_r           <= cnt_nxt;
         pair_clock_en   <= pclk_nxt;
         pair_ref_en     <= pref_nxt;
         fabric_clock_en <= fclk_nxt;
         fabric_ref_en   <= fclk_nxt;
         low_power_hold  <= lp_nxt;
         fsm_tick        <= tick_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_srst_write;
      wr_stb && addr == `GCFR_OFS_GLOBAL && wdata[`GCFR_BIT_SOFT_RST];
   endsequence

   sequence s_defaults_loaded;
      glb_r == 16'h0001 && fsm_r == `GCFR_RST_FSM_CLK && ch_r == `GCFR_RST_CH_CTRL && oe_r == `GCFR_RST_OUT_EN_A;
   endsequence

   a_srst_defaults: assert property (s_srst_write |=> s_defaults_loaded)
      else $error("soft reset did not reload defaults");

   a_srst_self_clear: assert property (glb_r[0] && wr_stb && !srst_wr |=> !glb_r[0])
      else $error("soft reset bit did not clear on next write");

   a_low_power_keeps: assert property (lp && !wr_stb |=> $stable(fsm_r) && $stable(ch_r) && $stable(oe_r))
      else $error("register changed in low power without a write");

   a_low_power_quiet: assert property (lp ##1 lp |-> pair_clock_en == '0 && !fabric_clock_en && !fsm_tick)
      else $error("outputs active in low power");

   // a shortened period lets the count overshoot once, so only a settled period is held exact
   a_tick_period: assert property (fsm_tick && $past(period) == $past(period, 2)
                                   |-> $past(cnt_r) == 10'($past(period) - 11'h001))
      else $error("state-machine tick off its period");

   a_prescale_code: assert property (fsm_r[9:6] == 4'h4 && ch_r[2:0] == 3'h6 |-> period == 11'h100)
      else $error("prescale decode wrong");

   a_divider_range: assert property (ch_r[2:0] == 3'h7 && fsm_r[9:6] == 4'h8 |-> period == 11'h400)
      else $error("divider decode wrong");

   a_gen_off_no_tick: assert property (!fsm_r[`GCFR_BIT_GEN_ON] |=> !fsm_tick)
      else $error("tick while generator off");

   a_logic_mute: assert property (cal_active && ch_r[11] |=> !fabric_clock_en && !fabric_ref_en)
      else $error("fabric outputs not muted in calibration");

   a_reserved_zero: assert property (rdata[6:3] == 4'h0 || addr != `GCFR_OFS_CH_CTRL)
      else $error("reserved bits read nonzero");

   for (genvar g = 0; g < PAIRS; g++) begin : g_pair_chk
      a_pair_override: assert property (!ch_r[12+g] |=> !pair_clock_en[g] && !pair_ref_en[g])
         else $error("disabled pair still enabled");
      a_pair_mute: assert property (cal_active && ch_r[7+g] |=> !pair_clock_en[g] && !pair_ref_en[g])
         else $error("pair not muted in calibration");
   end

endmodule

`default_nettype wire

// *** sim/gcfr_host_model.sv ***
/*
 * host model: configuration software talking to the register bank over
 * the serial port, 24-bit frames, read flag first, msb first.
 * assumes clk_sys of 40 MHz; sck is held low outside frames.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gcfr_consts.svh"

module gcfr_host_model #(
   parameter int HALF = 6
) (
   input  wire logic clk_sys,
   output logic      spi_sck,
   output logic      spi_cs_b,
   output logic      spi_sdi,
   input  wire logic spi_sdo
);
   // ---------------------------------------------------------------
   // software habits
   // ---------------------------------------------------------------
   // at a 40 MHz input every prescale and divider code stays within limits
   function automatic logic [15:0] tidy(input logic [6:0] a, input logic [15:0] d);
      case (a)
         `GCFR_OFS_GLOBAL:  tidy = d & 16'h0005;
         `GCFR_OFS_FSM_CLK: tidy = (d & 16'h03c0) | 16'h0023;
         `GCFR_OFS_CH_CTRL: tidy = d & 16'hff87;
         default:           tidy = d;
      endcase
   endfunction

   initial begin
      spi_sck = 1'b0;
      spi_cs_b = 1'b1;
      spi_sdi = 1'b0;
   end

   // ---------------------------------------------------------------
   // one whole frame; raw skips the habits so a scenario can misbehave
   // ---------------------------------------------------------------
   // half periods of six clocks leave margin over the three-clock sync
   task automatic xfer(input logic rd, input logic raw, input logic [6:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      logic [23:0] f;
      f = {rd, a, (raw ? d : tidy(a, d))};
      q = 16'h0000;
      @(posedge clk_sys);
      #1 spi_cs_b = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = f[i];
         repeat (HALF) @(posedge clk_sys);
         #1;
         if (i < 16) q[i] = spi_sdo;
         spi_sck = 1'b1;
         repeat (HALF) @(posedge clk_sys);
         #1 spi_sck = 1'b0;
      end
      repeat (HALF) @(posedge clk_sys);
      #1 spi_cs_b = 1'b1;
      spi_sdi = ~spi_sdi;   // released line shows no stale bit
      repeat (HALF) @(posedge clk_sys);
      #1;
   endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
/*
 * self-checking testbench of the register bank: register reset values,
 * state-machine clock division, output gating, low power and soft reset.
 * assumes the host model for all serial traffic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gcfr_consts.svh"

module tb;
   logic       clk_sys = 1'b0;
   logic       rst_b = 1'b0;
   logic       cal_active = 1'b0;
   logic       spi_sck, spi_cs_b, spi_sdi, spi_sdo;
   logic [3:0] pair_clock_en, pair_ref_en;
   logic       fabric_clock_en, fabric_ref_en, low_power_hold, fsm_tick;
   logic [15:0] q;
   int         num_errors = 0;
   int         checks_done = 0;
   int         n;

   always #12.5 clk_sys = ~clk_sys;

   gcfr_host_model host_u (.clk_sys(clk_sys), .spi_sck(spi_sck), .spi_cs_b(spi_cs_b),
                           .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
   gcfr_regbank #(.PAIRS(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .spi_sck(spi_sck),
      .spi_cs_b(spi_cs_b), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .cal_active(cal_active),
      .pair_clock_en(pair_clock_en), .pair_ref_en(pair_ref_en), .fabric_clock_en(fabric_clock_en),
      .fabric_ref_en(fabric_ref_en), .low_power_hold(low_power_hold), .fsm_tick(fsm_tick));

   // ---------------------------------------------------------------
   // shared checking and bus tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic raw = 1'b0);
      host_u.xfer(1'b0, raw, a, d, q);
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      host_u.xfer(1'b1, 1'b0, a, 16'h0000, q);
      check(q, exp);
   endtask

   // all enables packed: clock, ref, fabric pair, low power
   task automatic outs_chk(input logic [3:0] pc, input logic [3:0] pr, input logic fab, input logic lp);
      repeat (3) @(posedge clk_sys);
      #1 check({4'h0, pair_clock_en, pair_ref_en, fabric_clock_en, fabric_ref_en, low_power_hold, 1'b0},
               {4'h0, pc, pr, fab, fab, lp, 1'b0});
   endtask

   // cycles between two ticks, after skipping to the first one
   task automatic tick_gap(output int gap);
      gap = 0;
      for (int k = 0; k < 3000 && fsm_tick !== 1'b1; k++) @(posedge clk_sys) #1;
      do begin
         @(posedge clk_sys) #1;
         gap++;
      end while (fsm_tick !== 1'b1 && gap < 3000);
   endtask

   task automatic count_ticks(output int c);
      c = 0;
      repeat (600) begin
         @(posedge clk_sys) #1;
         if (fsm_tick === 1'b1) c++;
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values();
      rd_chk(`GCFR_OFS_GLOBAL, 16'h0000);
      rd_chk(`GCFR_OFS_FSM_CLK, 16'h0223);
      rd_chk(`GCFR_OFS_CH_CTRL, 16'hff86);
      rd_chk(`GCFR_OFS_OUT_EN_A, 16'h36ff);
      outs_chk(4'hf, 4'hf, 1'b1, 1'b0);
      tick_gap(n);
      check(n[15:0], 16'h0200);
   endtask

   // each decoded prescale code (2, 4, 8), dividers at both ends and between
   task automatic t_divide();
      logic [3:0] pre [4] = '{4'h2, 4'h4, 4'h8, 4'h2};
      logic [2:0] dv [4] = '{3'h0, 3'h6, 3'h7, 3'h1};
      for (int k = 0; k < 4; k++) begin
         wr(`GCFR_OFS_FSM_CLK, {6'h00, pre[k], 6'h23});
         wr(`GCFR_OFS_CH_CTRL, 16'hff80 | {13'h0000, dv[k]});
         tick_gap(n);
         check(n[15:0], 16'(int'(pre[k]) << dv[k]));
      end
      wr(`GCFR_OFS_FSM_CLK, 16'h0203, 1'b1);
      count_ticks(n);
      check(n[15:0], 16'h0000);
      wr(`GCFR_OFS_FSM_CLK, 16'h0223);
      wr(`GCFR_OFS_CH_CTRL, 16'hff86);
   endtask

   task automatic t_gating();
      logic [15:0] ch [4] = '{16'hf506, 16'h3f86, 16'hff86, 16'hff86};
      logic [7:0]  r4 [4] = '{8'hff, 8'hff, 8'ha5, 8'hff};
      logic        ca [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      logic [3:0]  pm;
      for (int k = 0; k < 4; k++) begin
         wr(`GCFR_OFS_CH_CTRL, ch[k]);
         wr(`GCFR_OFS_OUT_EN_A, {8'h36, r4[k]});
         cal_active = ca[k];
         pm = ch[k][15:12] & ~({4{ca[k]}} & ch[k][10:7]);
         outs_chk(pm & r4[k][3:0], pm & r4[k][7:4], ~(ca[k] & ch[k][11]), 1'b0);
      end
      cal_active = 1'b0;
      wr(`GCFR_OFS_OUT_EN_A, 16'h36ff);
   endtask

   task automatic t_low_power();
      wr(`GCFR_OFS_CH_CTRL, 16'h7f86);
      wr(`GCFR_OFS_GLOBAL, 16'h0004);
      outs_chk(4'h0, 4'h0, 1'b0, 1'b1);
      count_ticks(n);
      check(n[15:0], 16'h0000);
      rd_chk(`GCFR_OFS_CH_CTRL, 16'h7f86);
      wr(`GCFR_OFS_GLOBAL, 16'h0000);
      outs_chk(4'h7, 4'h7, 1'b1, 1'b0);
   endtask

   // soft reset while settings differ from defaults, then reserved places
   task automatic t_soft_reset();
      wr(`GCFR_OFS_OUT_EN_A, 16'h0000);
      wr(`GCFR_OFS_GLOBAL, 16'h0001);
      rd_chk(`GCFR_OFS_GLOBAL, 16'h0001);
      rd_chk(`GCFR_OFS_CH_CTRL, 16'hff86);
      rd_chk(`GCFR_OFS_OUT_EN_A, 16'h36ff);
      count_ticks(n);
      check(n[15:0], 16'h0000);
      wr(`GCFR_OFS_FSM_CLK, 16'h0223);
      rd_chk(`GCFR_OFS_GLOBAL, 16'h0000);
      outs_chk(4'hf, 4'hf, 1'b1, 1'b0);
      wr(`GCFR_OFS_CH_CTRL, 16'hffff, 1'b1);
      rd_chk(`GCFR_OFS_CH_CTRL, 16'hff87);
      wr(`GCFR_OFS_FSM_CLK, 16'hffff, 1'b1);
      rd_chk(`GCFR_OFS_FSM_CLK, 16'h07ff);
      wr(7'h01, 16'hffff, 1'b1);
      rd_chk(7'h01, 16'h0000);
      rd_chk(7'h7f, 16'h0000);
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      t_reset_values();
      t_divide();
      t_gating();
      t_low_power();
      t_soft_reset();
      report_and_stop();
   end

   // the run needs some 20000 cycles; five times that means a hang
   initial begin
      repeat (100000) @(posedge clk_sys);
      num_errors++;
      report_and_stop();
   end
endmodule

`default_nettype wire
